// *** msa_decode.sv ***
// Combinational page-0 address decoder
`timescale 1ns/10ps
module msa_decode (
    input  wire logic [19:0] addr,
    input  wire logic        rom_on,
    input  wire logic        max_mode,
    input  wire logic        single_chip,
    input  wire logic        ram_en,
    output logic             sel_reg,
    output logic             sel_ram,
    output logic             sel_rom,
    output logic             sel_ext,
    output logic             addr_err
);
    logic in_reg;
    logic in_ram;
    logic in_rom;
    logic in_space;

    always_comb begin
        in_reg   = (addr >= msa_pkg::REG_FIELD_LO) && (addr <= msa_pkg::REG_FIELD_HI);
        in_ram   = (addr >= msa_pkg::RAM_LO) && (addr <= msa_pkg::RAM_HI);
        in_rom   = addr <= msa_pkg::ROM_HI;
        in_space = max_mode || (addr <= msa_pkg::MIN_SPACE_HI);
        sel_reg  = in_reg;
        sel_ram  = !in_reg && in_ram && ram_en;
        sel_rom  = !in_reg && !sel_ram && in_rom && rom_on;
        sel_ext  = !in_reg && !sel_ram && !sel_rom && in_space && !single_chip;
        addr_err = !in_reg && !sel_ram && !sel_rom && !sel_ext;
    end
endmodule

// *** msa_ext_sys.sv ***
// External system model: mode strapping and off-chip access counter
`timescale 1ns/10ps
module msa_ext_sys (
    input  wire logic       clock,
    input  wire logic [2:0] want_code,
    input  wire logic       sel_ext_q,
    output logic            mode_pin_high,
    output logic            mode_pin_mid,
    output logic            mode_pin_low,
    output int              ext_count
);
    logic [2:0] strap_q = 3'h7;
    // Unusable codes are never strapped; the last legal code stays on the pins
    always @(posedge clock) begin
        if (want_code != 3'h0 && want_code != 3'h5) begin
            strap_q <= want_code;
        end
    end
    assign {mode_pin_high, mode_pin_mid, mode_pin_low} = strap_q;
    initial ext_count = 0;
    always @(posedge clock) begin
        if (sel_ext_q === 1'b1) begin
            ext_count <= ext_count + 1;
        end
    end
endmodule

// *** msa_pkg.sv ***
// Package: constants for mode selection and page-0 address decoding
package msa_pkg;
    typedef enum logic [2:0] {
        MSA_MODE_0       = 3'b000,
        MSA_MODE_EXP_MIN = 3'b001,
        MSA_MODE_EXP_MIN_ROM = 3'b010,
        MSA_MODE_EXP_MAX = 3'b011,
        MSA_MODE_EXP_MAX_ROM = 3'b100,
        MSA_MODE_5       = 3'b101,
        MSA_MODE_STANDBY = 3'b110,
        MSA_MODE_SINGLE  = 3'b111
    } msa_mode_e;

    localparam int          ADDR_W          = 20;
    localparam logic [19:0] RAM_CTRL_ADDR   = 20'h0fff9;
    localparam logic [19:0] MODE_CAP_ADDR   = 20'h0fffa;
    localparam logic [19:0] REG_FIELD_LO    = 20'h0ff80;
    localparam logic [19:0] REG_FIELD_HI    = 20'h0ffff;
    localparam logic [19:0] RAM_LO          = 20'h0fd80;
    localparam logic [19:0] RAM_HI          = 20'h0ff7f;
    localparam logic [19:0] ROM_HI          = 20'h03fff;
    localparam logic [19:0] MIN_SPACE_HI    = 20'h0ffff;
    localparam int          RAM_ENABLE_BIT  = 7;
    localparam logic        RAM_ENABLE_RST  = 1'b1;
    localparam logic [4:0]  MODE_CAP_FIXED  = 5'h18;
    localparam int          SYNC_STAGES     = 3;
endpackage

// *** msa_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module msa_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] held_q;

    initial begin
        if (WIDTH < 1) $error("msa_sync: WIDTH must be positive");
    end

    always_ff @(posedge clock) begin
        s1_q <= pin_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // A change only counts once the two later stages agree; the agreed level passes on
            // at once, so a reset held for four edges already captures settled pins
            assign pin_out[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : held_q[gi];
            always_ff @(posedge clock) begin
                if (srst) begin
                    held_q[gi] <= 1'b0;
                end else begin
                    held_q[gi] <= pin_out[gi];
                end
            end
        end
    endgenerate
endmodule

// *** msa_top.sv ***
// Mode latch, register field and address map for the microcontroller
`timescale 1ns/10ps
module msa_top (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        mode_pin_high,
    input  wire logic        mode_pin_mid,
    input  wire logic        mode_pin_low,
    input  wire logic [19:0] bus_addr,
    input  wire logic        bus_valid,
    input  wire logic        bus_write,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             sel_reg_q,
    output logic             sel_ram_q,
    output logic             sel_rom_q,
    output logic             sel_ext_q,
    output logic             addr_err_q,
    output logic             standby_q,
    output logic             max_mode_q,
    output logic             rom_enable_q,
    output logic             vectors_onchip_q,
    output logic             single_chip_q,
    output logic             save_code_page_q,
    output logic             port1_ctrl_bus_q,
    output logic             port2_data_bus_q,
    output logic             port34_addr_bus_q,
    output logic             port1_addr_bus_q,
    output logic             port7_addr_bus_q,
    output logic             port4_start_input_q,
    output logic             port1_start_input_q,
    output logic             port7_start_input_q,
    output logic             onchip_ram_enable_q
);
    logic [2:0]         pins_sync;
    logic [2:0]         mode_code_q;
    logic               mode_valid_q;
    logic               in_reset_q;
    msa_pkg::msa_mode_e mode_e;
    logic               dec_reg;
    logic               dec_ram;
    logic               dec_rom;
    logic               dec_ext;
    logic               dec_err;
    logic               acc_ram_wr;
    logic [7:0]         rd_d;

    msa_sync #(
        .WIDTH   (3)
    ) u_sync (
        .clock   (clock),
        .srst    (1'b0),
        .pin_in  ({mode_pin_high, mode_pin_mid, mode_pin_low}),
        .pin_out (pins_sync)
    );

    assign mode_e = msa_pkg::msa_mode_e'(mode_code_q);

    // Code tracks the pins while reset is held and freezes at release
    always_ff @(posedge clock) begin
        in_reset_q <= srst;
        if (srst) begin
            mode_code_q  <= pins_sync;
            mode_valid_q <= 1'b0;
        end else begin
            mode_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            standby_q        <= 1'b0;
            max_mode_q       <= 1'b0;
            rom_enable_q     <= 1'b0;
            vectors_onchip_q <= 1'b0;
            single_chip_q    <= 1'b0;
            save_code_page_q <= 1'b0;
        end else begin
            standby_q        <= (mode_e == msa_pkg::MSA_MODE_STANDBY);
            save_code_page_q <= 1'b0;
            case (mode_e)
                msa_pkg::MSA_MODE_EXP_MIN: begin
                    max_mode_q <= 1'b0;
                    rom_enable_q <= 1'b0;
                    vectors_onchip_q <= 1'b0;
                    single_chip_q <= 1'b0;
                end
                msa_pkg::MSA_MODE_EXP_MIN_ROM: begin
                    max_mode_q <= 1'b0;
                    rom_enable_q <= 1'b1;
                    vectors_onchip_q <= 1'b1;
                    single_chip_q <= 1'b0;
                end
                msa_pkg::MSA_MODE_EXP_MAX: begin
                    max_mode_q <= 1'b1;
                    rom_enable_q <= 1'b0;
                    vectors_onchip_q <= 1'b0;
                    single_chip_q <= 1'b0;
                    save_code_page_q <= 1'b1;
                end
                msa_pkg::MSA_MODE_EXP_MAX_ROM: begin
                    max_mode_q <= 1'b1;
                    rom_enable_q <= 1'b1;
                    vectors_onchip_q <= 1'b1;
                    single_chip_q <= 1'b0;
                    save_code_page_q <= 1'b1;
                end
                msa_pkg::MSA_MODE_SINGLE: begin
                    max_mode_q <= 1'b0;
                    rom_enable_q <= 1'b1;
                    vectors_onchip_q <= 1'b1;
                    single_chip_q <= 1'b1;
                end
                default: begin
                    // Unusable codes and standby: no rom and no off-chip; only the register field and enabled ram still decode
                    max_mode_q <= 1'b0;
                    rom_enable_q <= 1'b0;
                    vectors_onchip_q <= 1'b0;
                    single_chip_q <= 1'b1;
                end
            endcase
        end
    end

    // Pin ownership follows the latched mode
    always_ff @(posedge clock) begin
        if (srst) begin
            port1_ctrl_bus_q    <= 1'b0;
            port2_data_bus_q    <= 1'b0;
            port34_addr_bus_q   <= 1'b0;
            port1_addr_bus_q    <= 1'b0;
            port7_addr_bus_q    <= 1'b0;
            port4_start_input_q <= 1'b0;
            port1_start_input_q <= 1'b0;
            port7_start_input_q <= 1'b0;
        end else begin
            port1_ctrl_bus_q    <= mode_valid_q && !single_chip_q && !standby_q;
            port2_data_bus_q    <= mode_valid_q && !single_chip_q && !standby_q;
            port34_addr_bus_q   <= mode_valid_q && !single_chip_q && !standby_q;
            port1_addr_bus_q    <= max_mode_q;
            port7_addr_bus_q    <= max_mode_q;
            port4_start_input_q <= rom_enable_q && !single_chip_q;
            port1_start_input_q <= rom_enable_q && max_mode_q;
            port7_start_input_q <= rom_enable_q && max_mode_q;
        end
    end

    msa_decode u_dec (
        .addr        (bus_addr),
        .rom_on      (rom_enable_q),
        .max_mode    (max_mode_q),
        .single_chip (single_chip_q),
        .ram_en      (onchip_ram_enable_q),
        .sel_reg     (dec_reg),
        .sel_ram     (dec_ram),
        .sel_rom     (dec_rom),
        .sel_ext     (dec_ext),
        .addr_err    (dec_err)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            sel_reg_q  <= 1'b0;
            sel_ram_q  <= 1'b0;
            sel_rom_q  <= 1'b0;
            sel_ext_q  <= 1'b0;
            addr_err_q <= 1'b0;
        end else begin
            sel_reg_q  <= bus_valid && dec_reg;
            sel_ram_q  <= bus_valid && dec_ram;
            sel_rom_q  <= bus_valid && dec_rom;
            sel_ext_q  <= bus_valid && dec_ext;
            addr_err_q <= bus_valid && dec_err;
        end
    end

    assign acc_ram_wr = bus_valid && bus_write && (bus_addr == msa_pkg::RAM_CTRL_ADDR);

    always_ff @(posedge clock) begin
        if (srst) begin
            onchip_ram_enable_q <= msa_pkg::RAM_ENABLE_RST;
        end else if (acc_ram_wr) begin
            onchip_ram_enable_q <= bus_wdata[msa_pkg::RAM_ENABLE_BIT];
        end
    end

    // Writes to the mode register fall through; only reads are decoded
    always_comb begin
        rd_d = 8'h00;
        if (bus_addr == msa_pkg::MODE_CAP_ADDR) begin
            rd_d = {msa_pkg::MODE_CAP_FIXED, mode_code_q};
        end else if (bus_addr == msa_pkg::RAM_CTRL_ADDR) begin
            rd_d = {onchip_ram_enable_q, 7'h7f};
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            bus_rdata <= 8'h00;
        end else if (bus_valid && !bus_write) begin
            bus_rdata <= rd_d;
        end
    end

    mode_hold_a: assert property (@(posedge clock) disable iff (srst)
        !in_reset_q |-> $stable(mode_code_q))
        else $error("latched mode changed outside reset");
    mode_read_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && !bus_write && bus_addr == msa_pkg::MODE_CAP_ADDR
        |=> bus_rdata == {5'h18, mode_code_q})
        else $error("mode register read wrong");
    ram_bit_a: assert property (@(posedge clock) disable iff (srst)
        acc_ram_wr |=> onchip_ram_enable_q == $past(bus_wdata[7]))
        else $error("ram enable write lost");
    reg_prio_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && bus_addr >= 20'h0ff80 && bus_addr <= 20'h0ffff
        |=> sel_reg_q && !sel_ram_q && !sel_ext_q)
        else $error("register field not selected");
    ram_win_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && onchip_ram_enable_q && bus_addr >= 20'h0fd80 && bus_addr <= 20'h0ff7f
        |=> sel_ram_q)
        else $error("ram window not selected");
    ram_err_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && single_chip_q && !onchip_ram_enable_q
        && bus_addr >= 20'h0fd80 && bus_addr <= 20'h0ff7f |=> addr_err_q)
        else $error("no address error on disabled ram");
    single_ext_a: assert property (@(posedge clock) disable iff (srst)
        single_chip_q |=> !sel_ext_q)
        else $error("off-chip access in single-chip mode");
    rom_low_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && rom_enable_q && bus_addr <= 20'h03fff |=> sel_rom_q)
        else $error("rom not selected");
    min_range_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && !max_mode_q && bus_addr > 20'h0ffff |=> addr_err_q)
        else $error("minimum mode reached beyond page zero");

    // The code is taken on the last reset edge and the ram enable comes out of reset set
    cap_edge_a: assert property (@(posedge clock) disable iff (srst)
        in_reset_q |-> mode_code_q == $past(pins_sync))
        else $error("mode code not taken at reset release");
    ram_reset_a: assert property (@(posedge clock) disable iff (srst)
        in_reset_q |-> onchip_ram_enable_q)
        else $error("ram enable not set after reset");
    single_rom_a: assert property (@(posedge clock) disable iff (srst)
        mode_valid_q && mode_e == msa_pkg::MSA_MODE_SINGLE |-> single_chip_q && rom_enable_q)
        else $error("single-chip code not mapped to rom");
    standby_a: assert property (@(posedge clock) disable iff (srst)
        standby_q |-> !sel_rom_q && !sel_ram_q && !sel_ext_q)
        else $error("memory selected in standby");
    ram_off_ext_a: assert property (@(posedge clock) disable iff (srst)
        bus_valid && !onchip_ram_enable_q && !single_chip_q
        && bus_addr >= 20'h0fd80 && bus_addr <= 20'h0ff7f |=> sel_ext_q)
        else $error("disabled ram window not sent off-chip");

    // Mode levels that must move together
    vec_rom_a: assert property (@(posedge clock) disable iff (srst)
        vectors_onchip_q == rom_enable_q)
        else $error("vector location disagrees with rom mapping");
    cp_save_a: assert property (@(posedge clock) disable iff (srst)
        save_code_page_q == max_mode_q)
        else $error("code page save disagrees with maximum mode");

    // Pin ownership trails the mode levels by one cycle
    bus_pins_a: assert property (@(posedge clock) disable iff (srst)
        single_chip_q |=> !port1_ctrl_bus_q && !port2_data_bus_q && !port34_addr_bus_q)
        else $error("bus pins claimed in single-chip mode");
    exp_pins_a: assert property (@(posedge clock) disable iff (srst)
        mode_valid_q && !single_chip_q && !standby_q |=> port1_ctrl_bus_q && port2_data_bus_q && port34_addr_bus_q)
        else $error("expanded bus pins not claimed");
    max_pins_a: assert property (@(posedge clock) disable iff (srst)
        max_mode_q |=> port1_addr_bus_q && port7_addr_bus_q)
        else $error("extra address pins missing in maximum mode");
    start_in_a: assert property (@(posedge clock) disable iff (srst)
        rom_enable_q && !single_chip_q |=> port4_start_input_q)
        else $error("port 4 not started as inputs");
    start_max_a: assert property (@(posedge clock) disable iff (srst)
        rom_enable_q && max_mode_q |=> port1_start_input_q && port7_start_input_q)
        else $error("port 1 and 7 address pins not started as inputs");

    ext_cv: cover property (@(posedge clock) sel_ext_q);
    err_cv: cover property (@(posedge clock) addr_err_q);
    ramoff_cv: cover property (@(posedge clock) !onchip_ram_enable_q ##1 sel_ext_q);
    romsel_cv: cover property (@(posedge clock) sel_rom_q);
    stby_cv: cover property (@(posedge clock) standby_q && addr_err_q);
endmodule

// *** tb.sv ***
// Self-checking bench for mode latch and page-0 decode
`timescale 1ns/10ps
module tb;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [19:0] bus_addr = 20'h0;
    logic        bus_valid = 1'b0;
    logic        bus_write = 1'b0;
    logic [7:0]  bus_wdata = 8'h0;
    logic [2:0]  want_code = 3'h7;
    logic        mode_pin_high, mode_pin_mid, mode_pin_low;
    logic [7:0]  bus_rdata;
    logic        sel_reg_q, sel_ram_q, sel_rom_q, sel_ext_q, addr_err_q;
    logic        standby_q, max_mode_q, rom_enable_q, vectors_onchip_q, single_chip_q, save_code_page_q;
    logic        port1_ctrl_bus_q, port2_data_bus_q, port34_addr_bus_q, port1_addr_bus_q, port7_addr_bus_q;
    logic        port4_start_input_q, port1_start_input_q, port7_start_input_q, onchip_ram_enable_q;
    int          ext_count;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          exp_ext = 0;
    logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

    always #10 clock = ~clock;

    msa_ext_sys ext (.clock(clock), .want_code(want_code), .sel_ext_q(sel_ext_q), .mode_pin_high(mode_pin_high),
        .mode_pin_mid(mode_pin_mid), .mode_pin_low(mode_pin_low), .ext_count(ext_count));

    msa_top dut (.clock(clock), .srst(srst), .mode_pin_high(mode_pin_high), .mode_pin_mid(mode_pin_mid),
        .mode_pin_low(mode_pin_low), .bus_addr(bus_addr), .bus_valid(bus_valid), .bus_write(bus_write),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .sel_reg_q(sel_reg_q), .sel_ram_q(sel_ram_q),
        .sel_rom_q(sel_rom_q), .sel_ext_q(sel_ext_q), .addr_err_q(addr_err_q), .standby_q(standby_q),
        .max_mode_q(max_mode_q), .rom_enable_q(rom_enable_q), .vectors_onchip_q(vectors_onchip_q),
        .single_chip_q(single_chip_q), .save_code_page_q(save_code_page_q),
        .port1_ctrl_bus_q(port1_ctrl_bus_q), .port2_data_bus_q(port2_data_bus_q),
        .port34_addr_bus_q(port34_addr_bus_q), .port1_addr_bus_q(port1_addr_bus_q),
        .port7_addr_bus_q(port7_addr_bus_q), .port4_start_input_q(port4_start_input_q),
        .port1_start_input_q(port1_start_input_q), .port7_start_input_q(port7_start_input_q),
        .onchip_ram_enable_q(onchip_ram_enable_q));

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flags(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strap a code, pulse reset long enough to fill the pin synchroniser
    task automatic restart(input logic [2:0] c);
        @(posedge clock);
        want_code <= c;
        @(posedge clock);
        srst <= 1'b1;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // One access; the decode result is checked as {reg, ram, rom, ext, err}
    task automatic access(input logic [19:0] a, input logic w, input logic [7:0] d, input logic [4:0] exp);
        @(posedge clock);
        bus_addr <= a;
        bus_write <= w;
        bus_wdata <= d;
        bus_valid <= 1'b1;
        @(posedge clock);
        bus_valid <= 1'b0;
        #1;
        if (exp == 5'h02) exp_ext++;
        cmp_flags({9'h0, sel_reg_q, sel_ram_q, sel_rom_q, sel_ext_q, addr_err_q}, {9'h0, exp});
    endtask

    function automatic logic [13:0] exp_flags(input logic [2:0] c);
        logic mx, rm, sc, ex;
        mx = (c == 3'h3) || (c == 3'h4);
        rm = (c == 3'h2) || (c == 3'h4) || (c == 3'h7);
        sc = (c == 3'h7);
        ex = !sc;
        return {1'b0, mx, rm, rm, sc, mx, ex, ex, ex, mx, mx, (c == 3'h2) || (c == 3'h4), c == 3'h4, c == 3'h4};
    endfunction

    initial begin
        logic [2:0] c;
        logic [13:0] ef;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            c = codes[i];
            ef = exp_flags(c);
            restart(c);
            cmp_flags({standby_q, max_mode_q, rom_enable_q, vectors_onchip_q, single_chip_q, save_code_page_q,
                port1_ctrl_bus_q, port2_data_bus_q, port34_addr_bus_q, port1_addr_bus_q, port7_addr_bus_q,
                port4_start_input_q, port1_start_input_q, port7_start_input_q}, exp_flags(c));
            cmp_data({7'h0, onchip_ram_enable_q}, 8'h01);
            access(msa_pkg::MODE_CAP_ADDR, 1'b0, 8'h00, 5'h10);
            cmp_data(bus_rdata, {msa_pkg::MODE_CAP_FIXED, c});
            access(msa_pkg::RAM_CTRL_ADDR, 1'b0, 8'h00, 5'h10);
            cmp_data(bus_rdata, 8'hff);
            access(20'h00100, 1'b0, 8'h00, ef[11] ? 5'h04 : 5'h02);
            access(20'h04000, 1'b0, 8'h00, c == 3'h7 ? 5'h01 : 5'h02);
            access(20'h10000, 1'b0, 8'h00, ef[12] ? 5'h02 : 5'h01);
            access(20'h0fd80, 1'b0, 8'h00, 5'h08);
            access(msa_pkg::RAM_CTRL_ADDR, 1'b1, 8'h00, 5'h10);
            cmp_data({7'h0, onchip_ram_enable_q}, 8'h00);
            access(20'h0fd80, 1'b0, 8'h00, c == 3'h7 ? 5'h01 : 5'h02);
            access(msa_pkg::RAM_CTRL_ADDR, 1'b1, 8'h80, 5'h10);
            access(20'h0ff7f, 1'b0, 8'h00, 5'h08);
            access(20'h0ff80, 1'b0, 8'h00, 5'h10);
            // For codes 1, 3 and 4 the pins move after reset; the captured code must not follow them
            want_code <= ~c;
            access(msa_pkg::MODE_CAP_ADDR, 1'b1, 8'h00, 5'h10);
            repeat (6) @(posedge clock);
            access(msa_pkg::MODE_CAP_ADDR, 1'b0, 8'h00, 5'h10);
            cmp_data(bus_rdata, {msa_pkg::MODE_CAP_FIXED, c});
            $display("test mode %0d done", c);
        end
        restart(3'h6);
        cmp_data({7'h0, standby_q}, 8'h01);
        access(20'h00100, 1'b0, 8'h00, 5'h01);
        $display("test standby done");
        repeat (2) @(posedge clock);
        cmp_flags(ext_count[13:0], exp_ext[13:0]);
        results();
    end
endmodule
